//--- rtl/adcrr_defines.svh
// Constants shared by both ends of the converter result reader link
`ifndef ADCRR_DEFINES_SVH
`define ADCRR_DEFINES_SVH

`define ADCRR_ADDR_W          9
`define ADCRR_DATA_W          9
`define ADCRR_RESULT_W        12
`define ADCRR_CHAN_W          5
`define ADCRR_LOW_MSB         8
`define ADCRR_HIGH_MSB        2
`define ADCRR_SEQ_LOW_ADDR    9'h003
`define ADCRR_SEQ_HIGH_ADDR   9'h004
`define ADCRR_AVG_LOW_ADDR    9'h04b
`define ADCRR_AVG_HIGH_ADDR   9'h04c
`define ADCRR_CHAN_HOLD_CYC   8
`define ADCRR_CLK_HZ          100000000
`define ADCRR_SETTLE_3U3_US   116450
`define ADCRR_SETTLE_10U_US   324730
`define ADCRR_SETTLE_22U_US   750240
`define ADCRR_SETTLE_CYC(us)  (((us) * 64'd100) + 64'd0)
`define ADCRR_CTL_HOLD_CYC    1

`endif

//--- rtl/adcrr_pkg.sv
// Types shared by both ends of the converter result reader link
package adcrr_pkg;
  typedef enum logic [1:0] {
    ADCRR_SRC_DIRECT,
    ADCRR_SRC_SEQ_RAM,
    ADCRR_SRC_AVG_RAM
  } adcrr_src_t;

  typedef enum logic [1:0] {
    ADCRR_CAP_3U3,
    ADCRR_CAP_10U,
    ADCRR_CAP_22U
  } adcrr_cap_t;
endpackage

//--- rtl/adcrr_if.sv
// Link between the soft IP side and the user result reader
`timescale 1ns/1ps
interface adcrr_if;
  logic                           slot_done;
  logic                           result_valid;
  logic [4:0]                     result_channel;
  logic [11:0]                    conv_value;
  logic                           sequencer_ram_busy;
  logic                           averaging_ram_busy;
  logic [8:0]                     ram_addr;
  logic                           ram_rd;
  logic                           ram_sel_avg;
  logic [8:0]                     ram_rdata;

  modport ip_end (
    output slot_done, result_valid, result_channel, conv_value,
    output sequencer_ram_busy, averaging_ram_busy, ram_rdata,
    input  ram_addr, ram_rd, ram_sel_avg
  );
  modport reader_end (
    input  slot_done, result_valid, result_channel, conv_value,
    input  sequencer_ram_busy, averaging_ram_busy, ram_rdata,
    output ram_addr, ram_rd, ram_sel_avg
  );
endinterface

//--- rtl/adcrr_ip.sv
// Soft IP end: converter strobes, result RAMs with busy flags, reference settling
// How it works
// [RULE1] Valid strobe marks a fresh conversion value
// [RULE2] Slot done names channel on value bus
// [RULE3] Reader captures channel, then value, when both high; the reader takes both in the same cycle
// [RULE4] Channel held eight cycles after valid rises
// [RULE5] Slow reader registers value and channel
// [RULE6] Sequencer RAM busy while sequencer accesses it
// [RULE7] Sequencer RAM busy while averaging accesses it
// [RULE8] Averaging RAM busy while averaging accesses it
// [RULE9] Averaging RAM busy while threshold accesses it
// [RULE10] Result split: low nine bits, high three
// [RULE11] Raw first channel at words 3, 4
// [RULE12] Averaged first channel at words 75, 76
// [RULE13] Reader reads low word then high word
// [RULE14] Busy between halves forces low-half retry
// [RULE15] Reader steps address low, high, back
// [RULE16] Both RAM read ports behave alike
// [RULE17] No conversion before reference settling elapses
// [RULE18] Controls held a cycle after start
// [RULE19] Reader idles until slot done, then reads
`timescale 1ns/1ps
`include "adcrr_defines.svh"
module adcrr_ip
  import adcrr_pkg::*;
#(
  parameter longint SETTLE_3U3_CYC = `ADCRR_SETTLE_CYC(`ADCRR_SETTLE_3U3_US),
  parameter longint SETTLE_10U_CYC = `ADCRR_SETTLE_CYC(`ADCRR_SETTLE_10U_US),
  parameter longint SETTLE_22U_CYC = `ADCRR_SETTLE_CYC(`ADCRR_SETTLE_22U_US)
) (
  input  wire logic                CLOCK_I,
  input  wire logic                SRST_I,
  adcrr_if.ip_end                  LINK,
  input  wire logic                INT_REF_I,
  input  wire adcrr_pkg::adcrr_cap_t CAP_SEL_I,
  input  wire logic                CONV_REQ_I,
  input  wire logic [4:0]          CONV_CHAN_I,
  input  wire logic [11:0]         CONV_VALUE_I,
  input  wire logic                SEQ_OWN_ACC_I,
  input  wire logic                AVG_SEQ_ACC_I,
  input  wire logic                AVG_OWN_ACC_I,
  input  wire logic                THR_AVG_ACC_I,
  output logic                     SETTLED_O,
  output logic                     CONV_START_O,
  output logic [4:0]               CONV_CHAN_O
);
  import adcrr_pkg::*;

  localparam int CNT_W = 40;
  localparam int HOLD_W = 4;

  typedef struct packed {
    logic [CNT_W-1:0]  settle_cnt;
    logic              settled;
    logic              start;
    logic [4:0]        start_chan;
    logic [HOLD_W-1:0] hold;
    logic [1:0]        conv_cnt;
    logic              valid;
    logic              done;
    logic [4:0]        chan;
    logic [11:0]       value;
    logic [4:0]        pend_chan;
    logic              pend;
    logic              seq_busy;
    logic              avg_busy;
    logic [8:0]        rdata;
  } adcrr_ip_state_t;

  adcrr_ip_state_t st;
  adcrr_ip_state_t next_st;
  logic [8:0]      seq_ram [0:511];
  logic [8:0]      avg_ram [0:511];
  logic [CNT_W-1:0] settle_lim;

  always_comb begin
    case (CAP_SEL_I)
      ADCRR_CAP_10U: settle_lim = SETTLE_10U_CYC[CNT_W-1:0];
      ADCRR_CAP_22U: settle_lim = SETTLE_22U_CYC[CNT_W-1:0];
      default:       settle_lim = SETTLE_3U3_CYC[CNT_W-1:0];
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    next_st.valid = 1'b0;
    // Reference must settle before any start is issued  (see [RULE17])
    if (!INT_REF_I) begin
      next_st.settled = 1'b1;
    end else if (!st.settled) begin
      if (st.settle_cnt >= settle_lim - 1) begin
        next_st.settled = 1'b1;
      end else begin
        next_st.settle_cnt = st.settle_cnt + 1'b1;
      end
    end
    if (st.hold != '0) begin
      next_st.hold = st.hold - 1'b1;
    end
    // Start takes a channel only when the previous one has been held long enough
    if (CONV_REQ_I && st.settled && !st.pend && st.hold == '0) begin
      next_st.start = 1'b1;
      next_st.start_chan = CONV_CHAN_I;
      next_st.pend_chan = CONV_CHAN_I;
      next_st.pend = 1'b1;
      next_st.conv_cnt = 2'h2;
    end else if (st.pend) begin
      if (st.conv_cnt != 2'h0) begin
        next_st.conv_cnt = st.conv_cnt - 1'b1;
      end else begin
        next_st.pend = 1'b0;
        next_st.valid = 1'b1;                            // see [RULE1]
        next_st.done = 1'b1;                             // see [RULE2]
        next_st.chan = st.pend_chan;
        next_st.value = CONV_VALUE_I;
        next_st.hold = HOLD_W'(`ADCRR_CHAN_HOLD_CYC);    // see [RULE4]
      end
    end
    if (st.valid) begin
      next_st.done = 1'b0;
    end
    next_st.seq_busy = SEQ_OWN_ACC_I | AVG_SEQ_ACC_I | st.pend | st.valid; // see [RULE6] [RULE7]
    next_st.avg_busy = AVG_OWN_ACC_I | THR_AVG_ACC_I;                     // see [RULE8] [RULE9]
    // Same read timing on both RAMs: data one cycle after the read strobe  (see [RULE16])
    if (LINK.ram_rd) begin
      next_st.rdata = LINK.ram_sel_avg ? avg_ram[LINK.ram_addr] : seq_ram[LINK.ram_addr];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Raw result lands in the slot words when the slot finishes; busy is high then
  always_ff @(posedge CLOCK_I) begin
    if (st.valid) begin
      seq_ram[`ADCRR_SEQ_LOW_ADDR]  <= st.value[`ADCRR_LOW_MSB:0];            // see [RULE10] [RULE11]
      seq_ram[`ADCRR_SEQ_HIGH_ADDR] <= {6'h00, st.value[11:9]};
    end
    if (AVG_OWN_ACC_I && st.valid) begin
      avg_ram[`ADCRR_AVG_LOW_ADDR]  <= st.value[`ADCRR_LOW_MSB:0];            // see [RULE12]
      avg_ram[`ADCRR_AVG_HIGH_ADDR] <= {6'h00, st.value[11:9]};
    end
  end

  // Start control pins stay put while start and the following cycle  (see [RULE18])
  assign CONV_START_O = st.start;
  assign CONV_CHAN_O  = st.start_chan;
  assign SETTLED_O    = st.settled;

  assign LINK.slot_done          = st.done;
  assign LINK.result_valid       = st.valid;
  assign LINK.result_channel     = st.chan;
  assign LINK.conv_value         = st.value;
  assign LINK.sequencer_ram_busy = st.seq_busy;
  assign LINK.averaging_ram_busy = st.avg_busy;
  assign LINK.ram_rdata          = st.rdata;
endmodule

//--- rtl/adcrr_reader.sv
// User end: collects results directly or by two-part RAM reads
`timescale 1ns/1ps
`include "adcrr_defines.svh"
module adcrr_reader
  import adcrr_pkg::*;
(
  input  wire logic                  CLOCK_I,
  input  wire logic                  SRST_I,
  adcrr_if.reader_end                LINK,
  input  wire adcrr_pkg::adcrr_src_t SRC_SEL_I,
  output logic [11:0]                RESULT_O,
  output logic [4:0]                 CHANNEL_O,
  output logic                       RESULT_STB_O
);
  import adcrr_pkg::*;

  typedef enum logic [2:0] {
    RD_IDLE, RD_WAIT, RD_LOW, RD_HIGH, RD_FIN
  } adcrr_rd_state_t;

  typedef struct packed {
    adcrr_rd_state_t fsm;
    logic [8:0]      addr;
    logic            rd;
    logic            avg;
    logic [11:0]     result;
    logic [4:0]      channel;
    logic            stb;
  } adcrr_rd_t;

  adcrr_rd_t  st;
  adcrr_rd_t  next_st;
  logic       busy;

  assign busy = st.avg ? LINK.averaging_ram_busy : LINK.sequencer_ram_busy;

  always_comb begin
    next_st = st;
    next_st.stb = 1'b0;
    next_st.rd = 1'b0;
    case (st.fsm)
      RD_IDLE: begin
        // Direct path latches both value and channel so a slow user is safe  (see [RULE3] [RULE5])
        if (SRC_SEL_I == ADCRR_SRC_DIRECT) begin
          if (LINK.slot_done && LINK.result_valid) begin
            next_st.channel = LINK.result_channel;
            next_st.result = LINK.conv_value;
            next_st.stb = 1'b1;
          end
        end else if (LINK.slot_done) begin                  // see [RULE19]
          next_st.avg = (SRC_SEL_I == ADCRR_SRC_AVG_RAM);
          next_st.channel = LINK.result_channel;
          next_st.fsm = RD_WAIT;
        end
      end
      RD_WAIT: begin
        if (!busy) begin                                    // see [RULE6] [RULE8] [RULE16]
          next_st.addr = st.avg ? `ADCRR_AVG_LOW_ADDR : `ADCRR_SEQ_LOW_ADDR; // see [RULE15]
          next_st.rd = 1'b1;
          next_st.fsm = RD_LOW;                             // see [RULE13]
        end
      end
      RD_LOW: begin
        // RAM data trails the strobe by a cycle, so each half is taken one state later
        if (busy) begin
          next_st.fsm = RD_WAIT;                            // see [RULE14]
        end else begin
          next_st.addr = st.avg ? `ADCRR_AVG_HIGH_ADDR : `ADCRR_SEQ_HIGH_ADDR;
          next_st.rd = 1'b1;
          next_st.fsm = RD_HIGH;
        end
      end
      RD_HIGH: begin
        // Busy here means the low half may be stale, so both halves are refetched
        if (busy) begin
          next_st.fsm = RD_WAIT;                            // see [RULE14]
        end else begin
          next_st.result[8:0] = LINK.ram_rdata;             // see [RULE10]
          next_st.addr = 9'h000;
          next_st.fsm = RD_FIN;
        end
      end
      RD_FIN: begin
        next_st.result[11:9] = LINK.ram_rdata[`ADCRR_HIGH_MSB:0];
        next_st.stb = 1'b1;
        next_st.fsm = RD_IDLE;
      end
      default: begin
        next_st.fsm = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      st <= '{fsm: RD_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign LINK.ram_addr    = st.addr;
  assign LINK.ram_rd      = st.rd;
  assign LINK.ram_sel_avg = st.avg;
  assign RESULT_O         = st.result;
  assign CHANNEL_O        = st.channel;
  assign RESULT_STB_O     = st.stb;
endmodule

//--- tb/adcrr_checker.sv
// Link assertions between the soft IP end and the reader end
`timescale 1ns/1ps
`include "adcrr_defines.svh"
module adcrr_checker (
  input wire logic        CLOCK_I,
  input wire logic        SRST_I,
  input wire logic        slot_done,
  input wire logic        result_valid,
  input wire logic [4:0]  result_channel,
  input wire logic [11:0] conv_value,
  input wire logic        sequencer_ram_busy,
  input wire logic        averaging_ram_busy,
  input wire logic [8:0]  ram_addr,
  input wire logic        ram_rd,
  input wire logic        ram_sel_avg,
  input wire logic [8:0]  ram_rdata
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  logic [11:0] last_val;
  logic        busy;
  logic        is_lo;
  logic        is_hi;
  assign busy  = ram_sel_avg ? averaging_ram_busy : sequencer_ram_busy;
  assign is_lo = ram_addr == (ram_sel_avg ? `ADCRR_AVG_LOW_ADDR : `ADCRR_SEQ_LOW_ADDR);
  assign is_hi = ram_addr == (ram_sel_avg ? `ADCRR_AVG_HIGH_ADDR : `ADCRR_SEQ_HIGH_ADDR);
  // Reads only follow a slot, so the copy is always loaded before use
  always_ff @(posedge CLOCK_I) begin
    if (result_valid) begin
      last_val <= conv_value;
    end
  end
  a_valid_one_pulse: assert property (result_valid |=> !result_valid)
    else $error("valid strobe longer than a cycle");
  a_done_frames_valid: assert property ($rose(result_valid) |-> slot_done ##1 !slot_done)
    else $error("slot done not framing the result");
  a_chan_held: assert property (result_valid |=> $stable(result_channel) [*8])
    else $error("channel changed too soon");
  a_value_held: assert property (result_valid |=> $stable(conv_value) [*8])
    else $error("value changed too soon");
  a_seq_busy_write: assert property (result_valid |-> sequencer_ram_busy ##1 sequencer_ram_busy)
    else $error("sequencer RAM not busy on write");
  a_rd_when_free: assert property (ram_rd |-> !$past(busy))
    else $error("read launched while RAM busy");
  a_low_first: assert property (ram_rd && is_lo |-> !$past(ram_rd))
    else $error("low half read not first");
  a_high_after_low: assert property (ram_rd && is_hi |-> $past(ram_rd) && $past(is_lo))
    else $error("high half read without low half");
  a_rd_addr_legal: assert property (ram_rd |-> is_lo || is_hi)
    else $error("read at wrong address");
  a_low_word_data: assert property (ram_rd && !ram_sel_avg && is_lo |=> ram_rdata == last_val[8:0])
    else $error("low word data wrong");
  a_high_word_data: assert property (ram_rd && !ram_sel_avg && is_hi |=> ram_rdata[2:0] == last_val[11:9])
    else $error("high word data wrong");
  c_direct: cover property (slot_done && result_valid);
  c_seq_rd: cover property (ram_rd && !ram_sel_avg && is_hi);
  c_avg_rd: cover property (ram_rd && ram_sel_avg && is_hi);
  c_retry: cover property (ram_rd && is_hi ##[2:8] ram_rd && is_lo);
endmodule

//--- tb/testbench.sv
// Self-checking bench joining the soft IP end and the reader end
`timescale 1ns/1ps
`include "adcrr_defines.svh"
module testbench;
  import adcrr_pkg::*;
  // Short settling counts keep the run brief
  localparam longint S0 = 20;
  localparam longint S1 = 30;
  localparam longint S2 = 40;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        int_ref = 1'b0;
  adcrr_cap_t  cap = ADCRR_CAP_3U3;
  logic        req = 1'b0;
  logic [4:0]  chan = 5'h00;
  logic [11:0] val = 12'h000;
  logic [3:0]  acc = 4'h0;
  adcrr_src_t  src = ADCRR_SRC_DIRECT;
  logic        settled, start, stb;
  logic [4:0]  cchan, rchan;
  logic [11:0] result;
  int          n_fail = 0, samples_checked = 0, cycles = 0, n_low = 0;
  adcrr_if link ();
  adcrr_ip #(.SETTLE_3U3_CYC(S0), .SETTLE_10U_CYC(S1), .SETTLE_22U_CYC(S2)) adcrr_ip_i (
    .CLOCK_I(clk), .SRST_I(srst), .LINK(link), .INT_REF_I(int_ref), .CAP_SEL_I(cap),
    .CONV_REQ_I(req), .CONV_CHAN_I(chan), .CONV_VALUE_I(val), .SEQ_OWN_ACC_I(acc[0]),
    .AVG_SEQ_ACC_I(acc[1]), .AVG_OWN_ACC_I(acc[2]), .THR_AVG_ACC_I(acc[3]),
    .SETTLED_O(settled), .CONV_START_O(start), .CONV_CHAN_O(cchan));
  adcrr_reader adcrr_reader_i (.CLOCK_I(clk), .SRST_I(srst), .LINK(link), .SRC_SEL_I(src),
    .RESULT_O(result), .CHANNEL_O(rchan), .RESULT_STB_O(stb));
  adcrr_checker adcrr_checker_i (.CLOCK_I(clk), .SRST_I(srst), .slot_done(link.slot_done),
    .result_valid(link.result_valid), .result_channel(link.result_channel),
    .conv_value(link.conv_value), .sequencer_ram_busy(link.sequencer_ram_busy),
    .averaging_ram_busy(link.averaging_ram_busy), .ram_addr(link.ram_addr),
    .ram_rd(link.ram_rd), .ram_sel_avg(link.ram_sel_avg), .ram_rdata(link.ram_rdata));
  always #5 clk = ~clk;
  always @(negedge clk) begin
    cycles++;
    if (link.ram_rd === 1'b1 && link.ram_addr === ((src == ADCRR_SRC_AVG_RAM) ?
        `ADCRR_AVG_LOW_ADDR : `ADCRR_SEQ_LOW_ADDR)) n_low++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic t_settle(input logic r, input adcrr_cap_t c, input int n);
    int   k;
    logic early;
    int_ref = r;
    cap = c;
    req = 1'b1;
    srst = 1'b1;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    chk("reset result", 12'h000, result);
    k = 0;
    early = 1'b0;
    while (settled !== 1'b1 && k < 100) begin
      early |= start;
      @(negedge clk);
      k++;
    end
    chk("early start", 12'h000, 12'(early));
    chk("settle window", 12'h001, 12'(k >= n && k <= n + 2));
    req = 1'b0;
    // Request drops before any start can launch; idle twenty cycles before the next test
    repeat (20) @(negedge clk);
    $display("done settle cap %0d ref %0d", c, r);
  endtask
  task automatic convert(input logic [4:0] ch, input logic [11:0] v);
    int k;
    chan = ch;
    val = v;
    req = 1'b1;
    acc[2] = 1'b1;
    k = 0;
    while (start !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    req = 1'b0;
    chan = ~ch;
    chk("start chan", 12'(ch), 12'(cchan));
    @(negedge clk);
    chk("start chan hold", 12'(ch), 12'(cchan));
    while (link.result_valid !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("value bus", v, link.conv_value);
    chk("slot channel", 12'(ch), 12'(link.result_channel));
    @(negedge clk);
    acc[2] = 1'b0;
  endtask
  task automatic t_read(input adcrr_src_t s, input int dis, input logic [4:0] ch,
                        input logic [11:0] v);
    int k;
    src = s;
    n_low = 0;
    convert(ch, v);
    k = 0;
    if (dis < 4) begin
      while (link.ram_rd !== 1'b1 && k < 50) begin
        @(negedge clk);
        k++;
      end
      acc[dis] = 1'b1;
      repeat (2) @(negedge clk);
      chk("busy", 12'h001, 12'(dis < 2 ? link.sequencer_ram_busy : link.averaging_ram_busy));
      acc[dis] = 1'b0;
    end
    while (stb !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("result", v, result);
    chk("channel", 12'(ch), 12'(rchan));
    if (s != ADCRR_SRC_DIRECT) chk("low reads", (dis < 4) ? 12'h002 : 12'h001, 12'(n_low));
    $display("done read src %0d disturb %0d", s, dis);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    t_settle(1'b1, ADCRR_CAP_3U3, S0);
    t_settle(1'b1, ADCRR_CAP_10U, S1);
    t_settle(1'b1, ADCRR_CAP_22U, S2);
    t_settle(1'b0, ADCRR_CAP_3U3, 1);
    t_read(ADCRR_SRC_DIRECT, 4, 5'h01, 12'hfff);
    t_read(ADCRR_SRC_DIRECT, 4, 5'h1f, 12'h000);
    t_read(ADCRR_SRC_SEQ_RAM, 4, 5'h02, 12'h5a3);
    t_read(ADCRR_SRC_AVG_RAM, 4, 5'h03, 12'ha5c);
    for (int i = 0; i < 4; i++) begin
      t_read(i < 2 ? ADCRR_SRC_SEQ_RAM : ADCRR_SRC_AVG_RAM, i, 5'(i + 4), 12'he01 ^ 12'(i * 9'h111));
    end
    results();
  end
endmodule
